// [rtl/asr_ctrl.sv]
// Controller for a 256K x 32 asynchronous static memory with byte lanes
`timescale 1ns/1ns
module asr_ctrl
  import asr_pkg::*;
(
  input  wire logic              CLK,
  input  wire logic              RST,
  input  wire logic              REQ_VALID,
  input  wire asr_req_t          REQ,
  output logic                   REQ_READY,
  output logic                   RD_VALID,
  output logic [DATA_W-1:0]      RD_DATA,
  input  wire logic              RETAIN_REQ,
  output logic                   RETAIN_SAFE,
  output logic [ADDR_W-1:0]      WORD_ADDR,
  output logic                   CHIP_SELECT_N,
  output logic                   CHIP_SELECT_HIGH_TRUE,
  output logic                   WRITE_STROBE_N,
  output logic                   OUTPUT_GATE_N,
  output logic [LANES-1:0]       LANE_SELECT_N,
  output logic [DATA_W-1:0]      DATA_PINS_O,
  output logic                   DATA_PINS_OE_N,
  input  wire logic [DATA_W-1:0] DATA_PINS_I
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    asr_state_t          st;
    logic [CNT_W-1:0]    cnt;
    logic                ready;
    logic                rd_valid;
    logic [DATA_W-1:0]   rd_data;
    logic                retain_safe;
    logic [LANES-1:0]    lane_mask;
    asr_pins_t           pins;
  } asr_ctrl_state_t;

  asr_ctrl_state_t s_q;
  asr_ctrl_state_t s_d;
  logic [DATA_W-1:0] pins_sync;

  // ---------------------------------------------------------------
  // Pin synchroniser
  // ---------------------------------------------------------------
  // Read data comes from off-chip and is synchronised before use
  asr_sync #(.W(DATA_W)) u_sync (
    .clk  (CLK),
    .rst  (RST),
    .din  (DATA_PINS_I),
    .dout (pins_sync)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic asr_pins_t idle_pins(input logic [ADDR_W-1:0] a);
    asr_pins_t p;
    p.word_addr             = a;
    p.chip_select_n         = 1'b1;
    p.chip_select_high_true = 1'b0;
    p.write_strobe_n        = 1'b1;
    p.output_gate_n         = 1'b1;
    p.lane_select_n         = LANE_IDLE;
    p.data_out              = '0;
    p.data_oe_n             = 1'b1;
    return p;
  endfunction : idle_pins

  function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] d,
                                                   input logic [LANES-1:0]  m);
    logic [DATA_W-1:0] r;
    r = '0;
    for (int i = 0; i < LANES; i++) begin
      if (m[i]) begin
        r[i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
      end
    end
    return r;
  endfunction : lane_merge

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.rd_valid = 1'b0;
    case (s_q.st)
      ST_IDLE: begin
        s_d.pins  = idle_pins(s_q.pins.word_addr);
        s_d.ready = 1'b1;
        if (RETAIN_REQ) begin
          // Chip is already deselected here, so retention is safe at once
          s_d.ready       = 1'b0;
          s_d.retain_safe = 1'b1;
          s_d.st          = ST_RETAIN;
        end else if (REQ_VALID && s_q.ready && (REQ.lanes != '0)) begin
          s_d.ready     = 1'b0;
          s_d.lane_mask = REQ.lanes;
          // Address set with the selects, never after them
          s_d.pins.word_addr             = REQ.addr;
          s_d.pins.chip_select_n         = 1'b0;
          s_d.pins.chip_select_high_true = 1'b1;
          s_d.pins.lane_select_n         = ~REQ.lanes;
          s_d.cnt                        = '0;
          if (REQ.write) begin
            // Gate stays high, strobe falls with selects: memory never drives
            s_d.pins.write_strobe_n = 1'b0;
            s_d.pins.data_out       = REQ.wdata;
            s_d.st                  = ST_WR_FLOAT;
          end else begin
            s_d.pins.write_strobe_n = 1'b1;
            s_d.pins.output_gate_n  = 1'b0;
            s_d.st                  = ST_READ;
          end
        end
      end
      ST_READ: begin
        s_d.cnt = s_q.cnt + CNT_W'(1);
        // Wait covers address access plus two synchroniser stages
        if (s_q.cnt == CNT_W'(READ_WAIT_CYC + 2)) begin
          s_d.rd_valid = 1'b1;
          s_d.rd_data  = lane_merge(pins_sync, s_q.lane_mask);
          s_d.pins     = idle_pins(s_q.pins.word_addr);
          s_d.cnt      = '0;
          s_d.st       = ST_RECOVER;
        end
      end
      ST_WR_FLOAT: begin
        s_d.cnt = s_q.cnt + CNT_W'(1);
        // Drive data only once the strobe has held the memory off
        if (s_q.cnt == CNT_W'(WRITE_FLOAT_CYC - 1)) begin
          s_d.pins.data_oe_n = 1'b0;
          s_d.cnt            = '0;
          s_d.st             = ST_WR_DATA;
        end
      end
      ST_WR_DATA: begin
        s_d.cnt = s_q.cnt + CNT_W'(1);
        if (s_q.cnt == CNT_W'(WRITE_DATA_CYC - 1)) begin
          // End the write on the strobe; address, selects and data held
          s_d.pins.write_strobe_n = 1'b1;
          s_d.cnt                 = '0;
          s_d.st                  = ST_RECOVER;
        end
      end
      ST_RECOVER: begin
        // Data held one cycle past the strobe rise, then all released
        s_d.pins = idle_pins(s_q.pins.word_addr);
        s_d.cnt  = s_q.cnt + CNT_W'(1);
        if (s_q.cnt == CNT_W'(RECOVER_CYC - 1)) begin
          s_d.cnt   = '0;
          s_d.ready = 1'b1;
          s_d.st    = ST_IDLE;
        end
      end
      ST_RETAIN: begin
        s_d.pins = idle_pins(s_q.pins.word_addr);
        if (!RETAIN_REQ) begin
          // After supply is back, one read cycle passes before any access
          s_d.retain_safe = 1'b0;
          s_d.cnt         = '0;
          s_d.st          = ST_RECOVER;
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  // Pins leave reset deselected, so the memory never sees a stray write
  always_ff @(posedge CLK) begin
    if (RST) begin
      s_q             <= '0;
      s_q.st          <= ST_IDLE;
      s_q.pins        <= idle_pins('0);
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from flops
  // ---------------------------------------------------------------
  assign REQ_READY             = s_q.ready;
  assign RD_VALID              = s_q.rd_valid;
  assign RD_DATA               = s_q.rd_data;
  assign RETAIN_SAFE           = s_q.retain_safe;
  assign WORD_ADDR             = s_q.pins.word_addr;
  assign CHIP_SELECT_N         = s_q.pins.chip_select_n;
  assign CHIP_SELECT_HIGH_TRUE = s_q.pins.chip_select_high_true;
  assign WRITE_STROBE_N        = s_q.pins.write_strobe_n;
  assign OUTPUT_GATE_N         = s_q.pins.output_gate_n;
  assign LANE_SELECT_N         = s_q.pins.lane_select_n;
  assign DATA_PINS_O           = s_q.pins.data_out;
  assign DATA_PINS_OE_N        = s_q.pins.data_oe_n;
endmodule : asr_ctrl

// [rtl/asr_pkg.sv]
// Package: constants, timing counts and carrier types of the static memory controller
package asr_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 18;
  localparam int DATA_W  = 32;
  localparam int LANES   = 4;
  localparam int LANE_W  = 8;

  // ---------------------------------------------------------------
  // Timing in nanoseconds, and cycle counts at the clock rate
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS          = 100;
  localparam int READ_CYCLE_NS          = 10;
  localparam int ADDR_ACCESS_NS         = 10;
  localparam int WRITE_PULSE_NS         = 8;
  localparam int DATA_SETUP_WRITE_NS    = 6;
  localparam int STROBE_FLOAT_DELAY_NS  = 4;
  localparam int DESELECT_FLOAT_DELAY_NS = 4;

  function automatic int ns_min_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction : ns_min_cycles

  // Read: address and selects up, wait access time, sample
  localparam int READ_WAIT_CYC   = ns_min_cycles(ADDR_ACCESS_NS);
  // Write: strobe low for the float delay, then data driven for the pulse width
  localparam int WRITE_FLOAT_CYC = ns_min_cycles(STROBE_FLOAT_DELAY_NS);
  localparam int WRITE_DATA_CYC  = ns_min_cycles(WRITE_PULSE_NS);
  // Turnaround / recovery after any access
  localparam int RECOVER_CYC     = ns_min_cycles(READ_CYCLE_NS);
  localparam int CNT_W           = 4;

  // Pin reset levels
  localparam logic [LANES-1:0] LANE_IDLE = 4'hF;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_READ, ST_WR_FLOAT, ST_WR_DATA, ST_RECOVER, ST_RETAIN
  } asr_state_t;

  typedef struct packed {
    logic                write;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
    logic [LANES-1:0]    lanes;   // Active high: lane wanted
  } asr_req_t;

  typedef struct packed {
    logic [ADDR_W-1:0]   word_addr;
    logic                chip_select_n;
    logic                chip_select_high_true;
    logic                write_strobe_n;
    logic                output_gate_n;
    logic [LANES-1:0]    lane_select_n;
    logic [DATA_W-1:0]   data_out;
    logic                data_oe_n;
  } asr_pins_t;
endpackage : asr_pkg

// [rtl/asr_sync.sv]
// Two-stage synchroniser for pin data returning from the memory
`timescale 1ns/1ns
module asr_sync
  import asr_pkg::*;
#(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } asr_sync_state_t;

  asr_sync_state_t s_q;
  asr_sync_state_t s_d;

  // First stage is read only by the second stage
  always_comb begin
    s_d      = s_q;
    s_d.meta = din;
    s_d.sync = s_q.meta;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.sync;
endmodule : asr_sync

// [verif/asr_ctrl_chk.sv]
// Checker: pin and handshake assertions for the static memory controller
`timescale 1ns/1ns
module asr_ctrl_chk
  import asr_pkg::*;
(
  input wire logic              CLK,
  input wire logic              RST,
  input wire logic              REQ_VALID,
  input wire asr_req_t          REQ,
  input wire logic              REQ_READY,
  input wire logic              RD_VALID,
  input wire logic              RETAIN_REQ,
  input wire logic              RETAIN_SAFE,
  input wire logic [ADDR_W-1:0] WORD_ADDR,
  input wire logic              CHIP_SELECT_N,
  input wire logic              CHIP_SELECT_HIGH_TRUE,
  input wire logic              WRITE_STROBE_N,
  input wire logic              OUTPUT_GATE_N,
  input wire logic [LANES-1:0]  LANE_SELECT_N,
  input wire logic [DATA_W-1:0] DATA_PINS_O,
  input wire logic              DATA_PINS_OE_N
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic rd_take;
  logic wr_take;
  assign rd_take = REQ_VALID && REQ_READY && !RETAIN_REQ && !REQ.write && |REQ.lanes;
  assign wr_take = REQ_VALID && REQ_READY && !RETAIN_REQ && REQ.write && |REQ.lanes;
  a_rd_latency: assert property (rd_take |-> ##5 RD_VALID)
    else $error("read data not ready five cycles after take");
  a_rd_pins: assert property (rd_take |=> !OUTPUT_GATE_N && WRITE_STROBE_N
    && WORD_ADDR == $past(REQ.addr) && LANE_SELECT_N == ~$past(REQ.lanes))
    else $error("read pins do not match request");
  a_wr_selects: assert property (!WRITE_STROBE_N |-> !CHIP_SELECT_N
    && CHIP_SELECT_HIGH_TRUE && LANE_SELECT_N != 4'hF) else $error("strobe low while unselected");
  a_wr_pulse: assert property ($fell(WRITE_STROBE_N)
    |-> !WRITE_STROBE_N [*2] ##1 WRITE_STROBE_N) else $error("write strobe low time wrong");
  a_rd_spacing: assert property (rd_take |=> !REQ_READY [*5] ##1 REQ_READY)
    else $error("read recovery spacing wrong");
  a_wr_spacing: assert property (wr_take |=> !REQ_READY [*3] ##1 REQ_READY)
    else $error("write recovery spacing wrong");
  a_drive_late: assert property ($fell(DATA_PINS_OE_N) |-> $past(!WRITE_STROBE_N))
    else $error("data driven before strobe fell");
  a_no_fight: assert property (!DATA_PINS_OE_N |-> OUTPUT_GATE_N)
    else $error("data driven while gate low");
  a_wr_hold: assert property ($rose(WRITE_STROBE_N) |-> !DATA_PINS_OE_N
    && $stable(DATA_PINS_O) && $stable(WORD_ADDR)) else $error("write end not held");
  a_retain_off: assert property (RETAIN_SAFE |-> CHIP_SELECT_N || !CHIP_SELECT_HIGH_TRUE)
    else $error("chip selected in retention");
  a_retain_rec: assert property ($fell(RETAIN_SAFE) |-> !REQ_READY)
    else $error("no recovery cycle after retention");
  c_read: cover property (rd_take);
  c_write: cover property ($fell(WRITE_STROBE_N));
  c_retain: cover property ($rose(RETAIN_SAFE));
endmodule : asr_ctrl_chk
bind asr_ctrl asr_ctrl_chk i_asr_ctrl_chk (
  .CLK                   (CLK),
  .RST                   (RST),
  .REQ_VALID             (REQ_VALID),
  .REQ                   (REQ),
  .REQ_READY             (REQ_READY),
  .RD_VALID              (RD_VALID),
  .RETAIN_REQ            (RETAIN_REQ),
  .RETAIN_SAFE           (RETAIN_SAFE),
  .WORD_ADDR             (WORD_ADDR),
  .CHIP_SELECT_N         (CHIP_SELECT_N),
  .CHIP_SELECT_HIGH_TRUE (CHIP_SELECT_HIGH_TRUE),
  .WRITE_STROBE_N        (WRITE_STROBE_N),
  .OUTPUT_GATE_N         (OUTPUT_GATE_N),
  .LANE_SELECT_N         (LANE_SELECT_N),
  .DATA_PINS_O           (DATA_PINS_O),
  .DATA_PINS_OE_N        (DATA_PINS_OE_N)
);

// [verif/asr_mem_model.sv]
// Partner: behavioural 256K x 32 static memory with byte lanes
`timescale 1ns/1ns
module asr_mem_model
  import asr_pkg::*;
(
  input wire logic              CLK,
  input wire logic [ADDR_W-1:0] WORD_ADDR,
  input wire logic              CHIP_SELECT_N,
  input wire logic              CHIP_SELECT_HIGH_TRUE,
  input wire logic              WRITE_STROBE_N,
  input wire logic              OUTPUT_GATE_N,
  input wire logic [LANES-1:0]  LANE_SELECT_N,
  input wire logic [DATA_W-1:0] DATA_PINS_O,
  input wire logic              DATA_PINS_OE_N,
  output wire logic [DATA_W-1:0] DATA_PINS_I
);
  logic [DATA_W-1:0] mem [2**ADDR_W];
  logic [DATA_W-1:0] flt = 32'h5A5AA5A5;
  logic              sel;
  assign sel = !CHIP_SELECT_N && CHIP_SELECT_HIGH_TRUE;
  // Floating pins change every cycle so a stale value never passes
  always @(posedge CLK) flt <= ~flt;
  // Stored at write end; an undriven bus stores nothing
  always @(posedge WRITE_STROBE_N) begin
    for (int i = 0; i < LANES; i++) begin
      if (sel && !DATA_PINS_OE_N && !LANE_SELECT_N[i]) begin
        mem[WORD_ADDR][i*8+:8] <= DATA_PINS_O[i*8+:8];
      end
    end
  end
  // Zero-delay read path
  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign DATA_PINS_I[i*8+:8] = (sel && !OUTPUT_GATE_N && WRITE_STROBE_N && !LANE_SELECT_N[i])
      ? mem[WORD_ADDR][i*8+:8] : flt[i*8+:8];
  end
endmodule : asr_mem_model

// [verif/tb.sv]
// Testbench: controller against the memory model
`timescale 1ns/1ns
module tb;
  import asr_pkg::*;
  logic              CLK = 0, RST = 1, REQ_VALID = 0, RETAIN_REQ = 0;
  asr_req_t          REQ = '0;
  logic              REQ_READY, RD_VALID, RETAIN_SAFE, CHIP_SELECT_N, CHIP_SELECT_HIGH_TRUE;
  logic              WRITE_STROBE_N, OUTPUT_GATE_N, DATA_PINS_OE_N;
  logic [DATA_W-1:0] RD_DATA, DATA_PINS_O, DATA_PINS_I;
  logic [ADDR_W-1:0] WORD_ADDR;
  logic [LANES-1:0]  LANE_SELECT_N;
  int                errors = 0, compares = 0;
  initial forever #50 CLK = ~CLK;
  asr_ctrl i_asr_ctrl (
    .CLK                   (CLK),
    .RST                   (RST),
    .REQ_VALID             (REQ_VALID),
    .REQ                   (REQ),
    .REQ_READY             (REQ_READY),
    .RD_VALID              (RD_VALID),
    .RD_DATA               (RD_DATA),
    .RETAIN_REQ            (RETAIN_REQ),
    .RETAIN_SAFE           (RETAIN_SAFE),
    .WORD_ADDR             (WORD_ADDR),
    .CHIP_SELECT_N         (CHIP_SELECT_N),
    .CHIP_SELECT_HIGH_TRUE (CHIP_SELECT_HIGH_TRUE),
    .WRITE_STROBE_N        (WRITE_STROBE_N),
    .OUTPUT_GATE_N         (OUTPUT_GATE_N),
    .LANE_SELECT_N         (LANE_SELECT_N),
    .DATA_PINS_O           (DATA_PINS_O),
    .DATA_PINS_OE_N        (DATA_PINS_OE_N),
    .DATA_PINS_I           (DATA_PINS_I)
  );
  asr_mem_model i_asr_mem_model (
    .CLK                   (CLK),
    .WORD_ADDR             (WORD_ADDR),
    .CHIP_SELECT_N         (CHIP_SELECT_N),
    .CHIP_SELECT_HIGH_TRUE (CHIP_SELECT_HIGH_TRUE),
    .WRITE_STROBE_N        (WRITE_STROBE_N),
    .OUTPUT_GATE_N         (OUTPUT_GATE_N),
    .LANE_SELECT_N         (LANE_SELECT_N),
    .DATA_PINS_O           (DATA_PINS_O),
    .DATA_PINS_OE_N        (DATA_PINS_OE_N),
    .DATA_PINS_I           (DATA_PINS_I)
  );
  task finish_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : finish_test
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  function automatic logic [31:0] bm(input logic [3:0] l);
    for (int i = 0; i < 4; i++) bm[i*8+:8] = {8{l[i]}};
  endfunction : bm
  // Waits for ready at a falling edge, so the next rising edge takes it
  task req(input logic w, input logic [17:0] a, input logic [31:0] d, input logic [3:0] l);
    int n;
    n = 0;
    @(negedge CLK);
    while (REQ_READY !== 1'b1 && n < 50) begin
      n++;
      @(negedge CLK);
    end
    chk("REQ_READY", 1, REQ_READY);
    REQ_VALID = 1;
    REQ = {w, a, d, l};
    @(negedge CLK);
    REQ_VALID = 0;
  endtask : req
  task rd(input logic [17:0] a, input logic [3:0] l, input logic [31:0] e);
    int n;
    n = 0;
    req(0, a, 32'h0, l);
    while (RD_VALID !== 1'b1 && n < 20) begin
      n++;
      @(negedge CLK);
    end
    chk("RD_VALID", 1, RD_VALID);
    chk("RD_DATA", e, RD_DATA);
  endtask : rd
  task t_reset;
    chk("CHIP_SELECT_N", 1, CHIP_SELECT_N);
    chk("CHIP_SELECT_HIGH_TRUE", 0, CHIP_SELECT_HIGH_TRUE);
    chk("strobe gate oe", 3'h7, {WRITE_STROBE_N, OUTPUT_GATE_N, DATA_PINS_OE_N});
    chk("LANE_SELECT_N", 4'hF, LANE_SELECT_N);
    chk("ready valid safe", 3'h0, {REQ_READY, RD_VALID, RETAIN_SAFE});
    $display("t_reset done");
  endtask : t_reset
  task t_edges;
    req(1, 18'h0, 32'hDEADBEEF, 4'hF);
    req(1, 18'h3FFFF, 32'h01234567, 4'hF);
    rd(18'h0, 4'hF, 32'hDEADBEEF);
    rd(18'h3FFFF, 4'hF, 32'h01234567);
    $display("t_edges done");
  endtask : t_edges
  task t_lanes;
    logic [31:0] e;
    for (int i = 0; i < 4; i++) begin
      req(1, 18'h5, 32'h11223344, 4'hF);
      req(1, 18'h5, 32'hFFFFFFFF, 4'h1 << i);
      e = 32'h11223344 | bm(4'h1 << i);
      rd(18'h5, 4'hF, e);
      rd(18'h5, 4'h1 << i, e & bm(4'h1 << i));
    end
    $display("t_lanes done");
  endtask : t_lanes
  task t_no_lane;
    req(1, 18'h5, 32'h0, 4'h0);
    chk("REQ_READY", 1, REQ_READY);
    rd(18'h5, 4'hF, 32'h11223344 | bm(4'h8));
    $display("t_no_lane done");
  endtask : t_no_lane
  // Reset lands in the middle of a read; the controller must come back idle
  task t_mid_reset;
    req(0, 18'h5, 32'h0, 4'hF);
    RST = 1;
    repeat (2) @(negedge CLK);
    chk("CHIP_SELECT_N", 1, CHIP_SELECT_N);
    chk("gate ready valid", 3'h4, {OUTPUT_GATE_N, REQ_READY, RD_VALID});
    RST = 0;
    @(negedge CLK);
    chk("REQ_READY", 1, REQ_READY);
    rd(18'h5, 4'hF, 32'h11223344 | bm(4'h8));
    $display("t_mid_reset done");
  endtask : t_mid_reset
  task t_retain;
    @(negedge CLK);
    RETAIN_REQ = 1;
    REQ_VALID = 1;
    REQ = {1'b1, 18'h5, 32'h0, 4'hF};
    @(negedge CLK);
    REQ_VALID = 0;
    chk("RETAIN_SAFE", 1, RETAIN_SAFE);
    chk("REQ_READY", 0, REQ_READY);
    chk("CHIP_SELECT_N", 1, CHIP_SELECT_N);
    repeat (3) @(negedge CLK);
    RETAIN_REQ = 0;
    @(negedge CLK);
    chk("RETAIN_SAFE", 0, RETAIN_SAFE);
    chk("REQ_READY", 0, REQ_READY);
    rd(18'h5, 4'hF, 32'h11223344 | bm(4'h8));
    $display("t_retain done");
  endtask : t_retain
  initial begin
    repeat (20) @(negedge CLK);
    t_reset();
    RST = 0;
    t_edges();
    t_lanes();
    t_no_lane();
    t_mid_reset();
    t_retain();
    finish_test();
  end
  initial begin
    #400000;
    errors++;
    finish_test();
  end
endmodule : tb
